// File: psc_bus_if.sv
/*
 Parallel register bus between the host CPU end and the device end.
 Assumes one shared clock; strobes are one cycle, read data one cycle later.
*/
`timescale 1ns/10ps
`default_nettype none
interface psc_bus_if;
	psc_pkg::psc_addr_t addr;
	psc_pkg::psc_data_t wdata;
	logic wr;
	logic rd;
	psc_pkg::psc_data_t rdata;
	modport host (output addr, output wdata, output wr, output rd, input rdata);
	modport dev (input addr, input wdata, input wr, input rd, output rdata);
endinterface : psc_bus_if
`default_nettype wire

// File: psc_cfg.svh
/*
 Constants of the power-state controller: register offsets, field positions,
 reset values and timing figures.
 Assumes it is included by its bare name, after the package.
*/
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define PSC_OFS_WAKE_TEST 8'h00
`define PSC_OFS_PMC 8'h04
`define PSC_OFS_INTERRUPT_STATUS_REGISTER 8'h08
`define PSC_OFS_INT_EN 8'h0C

// ----------------------------------------------------------------
// power_mgmt_control fields and the interrupt bit
// ----------------------------------------------------------------
`define PSC_PMC_SEL_LSB 0
`define PSC_PMC_WAKEUP_STATUS_LSB 2
`define PSC_PMC_PIN_EN 4
`define PSC_PMC_WF_EN 5
`define PSC_PMC_ENERGY_WAKE_ENABLE 6
`define PSC_PMC_PULSE 7
`define PSC_PMC_READY 8
`define PSC_INT_WAKE 0

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define PSC_WAKEUP_STATUS_FRAME 2'b10
`define PSC_WAKEUP_STATUS_ENERGY 2'b01
`define PSC_WAKEUP_STATUS_NONE 2'b00
// fixed read pattern of the wake test register, value arbitrary
`define PSC_WAKE_TEST_VAL 32'h8765_4321

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PSC_CLK_MHZ 40
`define PSC_RESUME_US 2000
`define PSC_PULSE_MS 50
`define PSC_RESUME_CYC (`PSC_RESUME_US * `PSC_CLK_MHZ)
`define PSC_PULSE_CYC (`PSC_PULSE_MS * 1000 * `PSC_CLK_MHZ)

`endif

// File: psc_dev.sv
/*
 Device end: power-state controller with D0/D1/D2, wake source capture,
 wake-event pin, wake interrupt status and clock gating enables.
 Assumes the host keeps the bus protocol; carrier_i is asynchronous.
*/
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "psc_cfg.svh"

// How it works
// [R1] sleeping: only control register readable, ready cleared
// [R2] host avoids other accesses while not ready
// [R3] writes ignored until a read has occurred
// [R4] wakeup status readable to identify pin driver
// [R5] any write to wake test returns D0
// [R6] wake write resets state select to D0
// [R7] writing 01 enters D1, clearing ready
// [R8] D1 keeps PHY, internal, receive-PM clocks
// [R9] D1 detection drives pin when enabled
// [R10] D1 detection sets wakeup status 10
// [R11] host programs filter and enables before D1
// [R12] wake interrupt status ignores pin enable
// [R13] host only reads until ready after wake
// [R14] host sets PHY powerdown before D2 entry
// [R15] D2 stops all clocks, PHY energy detect
// [R16] carrier present at D2 entry detected immediately
// [R17] D2 carrier drives pin when enabled
// [R18] D2 carrier sets wakeup status 01
// [R19] host clears PHY powerdown after ready
// [R20] configuration kept through both saving states
// [R21] pulse select: 50 ms pin, else static
// [R22] interrupt status sticky, one clears after source
// [R23] ready returns within 2 ms of wake
// [R24] D0 encodes 00; entry right after write
module psc_dev #(
	parameter int RESUME_CYC = `PSC_RESUME_CYC,
	parameter int PULSE_CYC = `PSC_PULSE_CYC
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// register bus
	psc_bus_if.dev bus,
	// wake sources
	input wire logic wake_frame_det_i,
	input wire logic carrier_i,
	// wake outputs
	output logic wake_pin_o,
	output logic irq_o,
	// clock enables and power state
	output logic mac_clk_en_o,
	output logic host_clk_en_o,
	output logic rxpm_clk_en_o,
	output logic int_clk_en_o,
	output logic phy_low_power_o,
	output psc_pkg::psc_pstate_t state_o
);
	import psc_pkg::*;

	localparam int CW = 24;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	psc_pstate_t state_ff;
	logic ready_ff;
	logic [CW-1:0] rdy_cnt_ff;
	logic armed_ff;
	logic [1:0] wakeup_status_ff;
	logic pin_en_ff;
	logic wf_en_ff;
	logic energy_wake_enable_ff;
	logic pulse_sel_ff;
	logic interrupt_status_register_ff;
	logic int_en_ff;
	logic pme_d_ff;
	logic [CW-1:0] pulse_cnt_ff;
	logic car_s1_ff;
	logic car_s2_ff;
	logic car_s3_ff;
	logic car_lvl_ff;
	logic wake_pin_ff;
	logic irq_ff;
	psc_data_t rdata_ff;

	function automatic logic psc_hit(input psc_addr_t a, input psc_addr_t ofs);
		psc_hit = (a == ofs);
	endfunction : psc_hit

	// ----------------------------------------------------------------
	// access decode
	// ----------------------------------------------------------------
	wire in_sleep = (state_ff != PSC_D0);
	wire open_acc = ready_ff & ~in_sleep;
	wire wr_ok = bus.wr & armed_ff; // [R3]
	wire wake_wr = wr_ok & in_sleep & psc_hit(bus.addr, `PSC_OFS_WAKE_TEST); // [R5]
	wire cfg_wr = wr_ok & open_acc; // [R1]
	wire pmc_wr = cfg_wr & psc_hit(bus.addr, `PSC_OFS_PMC);
	wire sts_wr = cfg_wr & psc_hit(bus.addr, `PSC_OFS_INTERRUPT_STATUS_REGISTER);
	wire en_wr = cfg_wr & psc_hit(bus.addr, `PSC_OFS_INT_EN);
	wire [1:0] sel_w = bus.wdata[`PSC_PMC_SEL_LSB+1:`PSC_PMC_SEL_LSB];
	// code 11 is no state, so such a write leaves the state alone
	wire enter_sleep = pmc_wr & ((sel_w == PSC_D1) | (sel_w == PSC_D2)); // [R24]
	wire rd_ok = open_acc | psc_hit(bus.addr, `PSC_OFS_PMC); // [R1]

	// ----------------------------------------------------------------
	// wake detection
	// ----------------------------------------------------------------
	wire frame_hit = (state_ff == PSC_D1) & wake_frame_det_i; // [R9]
	// level test, so carrier already up at entry hits on the next edge
	wire energy_hit = (state_ff == PSC_D2) & car_lvl_ff; // [R16]
	wire [1:0] wakeup_status_clr = pmc_wr ? bus.wdata[`PSC_PMC_WAKEUP_STATUS_LSB+1:`PSC_PMC_WAKEUP_STATUS_LSB] : 2'b00;
	wire [1:0] wakeup_status_set = (frame_hit ? `PSC_WAKEUP_STATUS_FRAME : `PSC_WAKEUP_STATUS_NONE) // [R10]
		| (energy_hit ? `PSC_WAKEUP_STATUS_ENERGY : `PSC_WAKEUP_STATUS_NONE); // [R18]
	// set wins over the one-to-clear
	wire [1:0] nxt_wakeup_status = (wakeup_status_ff & ~wakeup_status_clr) | wakeup_status_set;
	wire pme_int = (wakeup_status_ff[1] & wf_en_ff) | (wakeup_status_ff[0] & energy_wake_enable_ff);
	wire sts_clr = sts_wr & bus.wdata[`PSC_INT_WAKE];
	wire nxt_interrupt_status_register = pme_int | (interrupt_status_register_ff & ~sts_clr); // [R12] [R22]
	wire pme_rise = pme_int & ~pme_d_ff;
	wire pulse_act = (pulse_cnt_ff != '0);
	wire nxt_wake_pin = pin_en_ff & pme_int & (~pulse_sel_ff | pulse_act); // [R9] [R17] [R21]

	wire psc_data_t pmc_word = {23'h00_0000, ready_ff, pulse_sel_ff, energy_wake_enable_ff, wf_en_ff,
		pin_en_ff, wakeup_status_ff, state_ff}; // [R4]
	wire psc_data_t rd_mux =
		psc_hit(bus.addr, `PSC_OFS_PMC) ? pmc_word :
		psc_hit(bus.addr, `PSC_OFS_WAKE_TEST) ? `PSC_WAKE_TEST_VAL :
		psc_hit(bus.addr, `PSC_OFS_INTERRUPT_STATUS_REGISTER) ? {31'h0000_0000, interrupt_status_register_ff} :
		psc_hit(bus.addr, `PSC_OFS_INT_EN) ? {31'h0000_0000, int_en_ff} :
		32'h0000_0000;
	wire psc_data_t nxt_rdata = (bus.rd & rd_ok) ? rd_mux : 32'h0000_0000;

	// ----------------------------------------------------------------
	// power state and ready
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_ff <= PSC_D0;
			ready_ff <= 1'b1;
			rdy_cnt_ff <= '0;
		end
		else if (wake_wr)
		begin
			state_ff <= PSC_D0; // [R6]
			rdy_cnt_ff <= CW'(RESUME_CYC); // [R23]
		end
		else if (enter_sleep)
		begin
			state_ff <= psc_pstate_t'(sel_w); // [R7] [R15]
			ready_ff <= 1'b0; // [R1]
		end
		else if (rdy_cnt_ff != '0)
		begin
			rdy_cnt_ff <= rdy_cnt_ff - CW'(1);
			if (rdy_cnt_ff == CW'(1))
			begin
				ready_ff <= 1'b1; // [R23]
			end
		end
	end

	// first read after reset or wake unlocks writes
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			armed_ff <= 1'b0;
		else if (wake_wr)
			armed_ff <= 1'b0; // [R3]
		else if (bus.rd)
			armed_ff <= 1'b1; // [R3]
	end

	// ----------------------------------------------------------------
	// configuration, kept in every state
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pin_en_ff <= 1'b0;
			wf_en_ff <= 1'b0;
			energy_wake_enable_ff <= 1'b0;
			pulse_sel_ff <= 1'b0;
			int_en_ff <= 1'b0;
		end
		else if (pmc_wr)
		begin
			pin_en_ff <= bus.wdata[`PSC_PMC_PIN_EN]; // [R20]
			wf_en_ff <= bus.wdata[`PSC_PMC_WF_EN];
			energy_wake_enable_ff <= bus.wdata[`PSC_PMC_ENERGY_WAKE_ENABLE];
			pulse_sel_ff <= bus.wdata[`PSC_PMC_PULSE];
		end
		else if (en_wr)
			int_en_ff <= bus.wdata[`PSC_INT_WAKE];
	end

	// ----------------------------------------------------------------
	// carrier synchroniser, change taken once stages two and three agree
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			car_s1_ff <= 1'b0;
			car_s2_ff <= 1'b0;
			car_s3_ff <= 1'b0;
			car_lvl_ff <= 1'b0;
		end
		else
		begin
			car_s1_ff <= carrier_i;
			car_s2_ff <= car_s1_ff;
			car_s3_ff <= car_s2_ff;
			if (car_s2_ff == car_s3_ff)
				car_lvl_ff <= car_s3_ff;
		end
	end

	// ----------------------------------------------------------------
	// wake status, interrupt status and pin
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wakeup_status_ff <= `PSC_WAKEUP_STATUS_NONE;
			interrupt_status_register_ff <= 1'b0;
			pme_d_ff <= 1'b0;
			pulse_cnt_ff <= '0;
			wake_pin_ff <= 1'b0;
			irq_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end
		else
		begin
			wakeup_status_ff <= nxt_wakeup_status;
			interrupt_status_register_ff <= nxt_interrupt_status_register;
			pme_d_ff <= pme_int;
			if (pme_rise)
				pulse_cnt_ff <= CW'(PULSE_CYC); // [R21]
			else if (pulse_act)
				pulse_cnt_ff <= pulse_cnt_ff - CW'(1);
			wake_pin_ff <= nxt_wake_pin;
			irq_ff <= nxt_interrupt_status_register & int_en_ff;
			rdata_ff <= nxt_rdata;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign bus.rdata = rdata_ff;
	assign wake_pin_o = wake_pin_ff;
	assign irq_o = irq_ff;
	assign mac_clk_en_o = (state_ff == PSC_D0); // [R8] [R15]
	assign host_clk_en_o = (state_ff == PSC_D0);
	assign rxpm_clk_en_o = (state_ff != PSC_D2); // [R8]
	assign int_clk_en_o = (state_ff != PSC_D2); // [R8] [R15]
	assign phy_low_power_o = (state_ff == PSC_D2); // [R15]
	assign state_o = state_ff;
endmodule : psc_dev
`default_nettype wire

// File: psc_host.sv
/*
 Host end: forwards user register accesses onto the bus while keeping the
 access discipline around the power-saving states.
 Assumes the user side issues at most one request per cycle.
*/
`timescale 1ns/10ps
`default_nettype none
`include "psc_cfg.svh"

module psc_host (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// register bus
	psc_bus_if.host bus,
	// user command port
	input wire psc_pkg::psc_addr_t usr_addr_i,
	input wire psc_pkg::psc_data_t usr_wdata_i,
	input wire logic usr_wr_i,
	input wire logic usr_rd_i,
	output psc_pkg::psc_data_t usr_rdata_o,
	output logic usr_rvalid_o,
	output logic usr_refused_o,
	// status
	output logic dev_ready_o,
	output logic phy_energy_powerdown_o
);
	import psc_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic init_ff;
	logic pend_ff;
	logic sleep_ff;
	logic woke_ff;
	logic was_d2_ff;
	logic edpd_ff;
	logic pmc_rd_ff;
	logic usr_rd_ff;
	logic usr_rd_dly_ff;
	psc_addr_t addr_ff;
	psc_data_t wdata_ff;
	logic wr_ff;
	logic rd_ff;
	psc_data_t usr_rdata_ff;
	logic usr_rvalid_ff;
	logic refused_ff;

	// ----------------------------------------------------------------
	// request screening
	// ----------------------------------------------------------------
	wire busy = init_ff | pend_ff;
	wire is_pmc = (usr_addr_i == `PSC_OFS_PMC);
	wire is_wake = (usr_addr_i == `PSC_OFS_WAKE_TEST);
	wire [1:0] sel_w = usr_wdata_i[`PSC_PMC_SEL_LSB+1:`PSC_PMC_SEL_LSB];
	wire ok_rd = usr_rd_i & ~busy & (~sleep_ff | is_pmc); // [R2] [R13]
	wire ok_wr = usr_wr_i & ~busy & (sleep_ff ? (is_wake & ~woke_ff) : 1'b1); // [R2] [R13]
	wire d2_hold = ok_wr & is_pmc & (sel_w == PSC_D2) & ~edpd_ff; // [R14]
	wire fwd_wr = (ok_wr & ~d2_hold) | pend_ff;
	wire psc_addr_t fwd_addr = pend_ff ? `PSC_OFS_PMC : usr_addr_i;
	wire psc_data_t fwd_data = pend_ff ? wdata_ff : usr_wdata_i;
	wire [1:0] fwd_sel = fwd_data[`PSC_PMC_SEL_LSB+1:`PSC_PMC_SEL_LSB];
	wire fwd_sleep = fwd_wr & (fwd_addr == `PSC_OFS_PMC)
		& ((fwd_sel == PSC_D1) | (fwd_sel == PSC_D2)); // [R11]
	wire fwd_wake = fwd_wr & sleep_ff & (fwd_addr == `PSC_OFS_WAKE_TEST);
	wire seen_ready = pmc_rd_ff & bus.rdata[`PSC_PMC_READY];
	wire seen_busy = pmc_rd_ff & ~bus.rdata[`PSC_PMC_READY];
	wire refuse = (usr_rd_i & ~ok_rd) | (usr_wr_i & ~ok_wr);

	// ----------------------------------------------------------------
	// bus drive
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			addr_ff <= `PSC_OFS_PMC;
			wdata_ff <= 32'h0000_0000;
			wr_ff <= 1'b0;
			rd_ff <= 1'b0;
			init_ff <= 1'b1;
			pend_ff <= 1'b0;
		end
		else
		begin
			wr_ff <= fwd_wr;
			rd_ff <= init_ff | ok_rd; // [R3]
			init_ff <= 1'b0;
			pend_ff <= d2_hold;
			if (init_ff)
				addr_ff <= `PSC_OFS_PMC;
			else if (fwd_wr | ok_rd)
				addr_ff <= fwd_addr;
			if (fwd_wr | d2_hold)
				wdata_ff <= fwd_data;
		end
	end

	// ----------------------------------------------------------------
	// tracking of the device's readiness
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sleep_ff <= 1'b1;
			woke_ff <= 1'b0;
			was_d2_ff <= 1'b0;
			edpd_ff <= 1'b0;
			pmc_rd_ff <= 1'b0;
			usr_rd_ff <= 1'b0;
			usr_rd_dly_ff <= 1'b0;
		end
		else
		begin
			pmc_rd_ff <= rd_ff & (addr_ff == `PSC_OFS_PMC);
			usr_rd_ff <= ok_rd;
			// bus data stand two edges after the request is taken
			usr_rd_dly_ff <= usr_rd_ff;
			if (d2_hold)
				edpd_ff <= 1'b1; // [R14]
			if (fwd_sleep)
			begin
				sleep_ff <= 1'b1;
				was_d2_ff <= (fwd_sel == PSC_D2);
			end
			else if (fwd_wake)
				woke_ff <= 1'b1;
			else if (seen_ready)
			begin
				sleep_ff <= 1'b0; // [R13]
				woke_ff <= 1'b0;
				was_d2_ff <= 1'b0;
				if (was_d2_ff)
					edpd_ff <= 1'b0; // [R19]
			end
			else if (seen_busy)
				sleep_ff <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// user answers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			usr_rdata_ff <= 32'h0000_0000;
			usr_rvalid_ff <= 1'b0;
			refused_ff <= 1'b0;
		end
		else
		begin
			usr_rvalid_ff <= usr_rd_dly_ff;
			if (usr_rd_dly_ff)
				usr_rdata_ff <= bus.rdata;
			refused_ff <= refuse;
		end
	end

	assign bus.addr = addr_ff;
	assign bus.wdata = wdata_ff;
	assign bus.wr = wr_ff;
	assign bus.rd = rd_ff;
	assign usr_rdata_o = usr_rdata_ff;
	assign usr_rvalid_o = usr_rvalid_ff;
	assign usr_refused_o = refused_ff;
	assign dev_ready_o = ~sleep_ff;
	assign phy_energy_powerdown_o = edpd_ff;
endmodule : psc_host
`default_nettype wire

// File: psc_link_asserts.sv
/*
 Checker of the power-state link: watches the bus and the device's state
 and clock-enable outputs.
 Assumes one clock domain and an instance beside the bus interface.
*/
`timescale 1ns/10ps
`default_nettype none
`include "psc_cfg.svh"
module psc_link_asserts (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// bus
	input wire psc_pkg::psc_addr_t addr,
	input wire psc_pkg::psc_data_t wdata,
	input wire logic wr,
	input wire logic rd,
	input wire psc_pkg::psc_data_t rdata,
	// device state
	input wire psc_pkg::psc_pstate_t state_o,
	input wire logic mac_clk_en_o,
	input wire logic host_clk_en_o,
	input wire logic rxpm_clk_en_o,
	input wire logic int_clk_en_o,
	input wire logic phy_low_power_o
);
	import psc_pkg::*;
	// ----------------------------------------------------------------
	// helper: device open for writes (read seen, ready seen)
	// ----------------------------------------------------------------
	logic pmc_rd_ff;
	logic open_ff;
	wire logic wake_wr = wr && addr == `PSC_OFS_WAKE_TEST && state_o != PSC_D0;
	wire logic rdy_seen = pmc_rd_ff && rdata[`PSC_PMC_READY];
	wire logic nxt_open = (wake_wr || state_o != PSC_D0) ? 1'b0 : (rdy_seen | open_ff);
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pmc_rd_ff <= 1'b0;
			open_ff <= 1'b0;
		end
		else
		begin
			pmc_rd_ff <= rd && addr == `PSC_OFS_PMC;
			open_ff <= nxt_open;
		end
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);
	sequence s_wake;
		wake_wr;
	endsequence
	sequence s_enter(logic [1:0] code);
		wr && addr == `PSC_OFS_PMC && wdata[1:0] == code && state_o == PSC_D0 && open_ff;
	endsequence
	chk_enter_d1: assert property (s_enter(2'b01) |=> state_o == PSC_D1)
		else $error("sleep state one not entered");
	chk_enter_d2: assert property (s_enter(2'b10) |=> state_o == PSC_D2 && phy_low_power_o)
		else $error("sleep state two not entered");
	chk_wake_write: assert property (s_wake |=> state_o == PSC_D0)
		else $error("wake write did not return to normal state");
	chk_sleep_held: assert property (state_o != PSC_D0 && !wake_wr |=> $stable(state_o))
		else $error("sleep state left without wake write");
	chk_d1_clocks: assert property (state_o == PSC_D1 |-> rxpm_clk_en_o && int_clk_en_o
		&& !mac_clk_en_o && !host_clk_en_o) else $error("clock enables wrong in state one");
	chk_d2_clocks: assert property (state_o == PSC_D2 |-> !rxpm_clk_en_o && !int_clk_en_o
		&& !mac_clk_en_o && !host_clk_en_o) else $error("clock enables wrong in state two");
	chk_sleep_not_ready: assert property (rd && addr == `PSC_OFS_PMC && state_o != PSC_D0
		|=> !rdata[`PSC_PMC_READY]) else $error("ready read high while asleep");
	chk_sel_field_read: assert property (rd && addr == `PSC_OFS_PMC
		|=> rdata[1:0] == $past(state_o)) else $error("select field differs from state");
endmodule : psc_link_asserts
`default_nettype wire

// File: psc_pkg.sv
/*
 Types shared by both ends of the power-state controller link.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package psc_pkg;
	typedef logic [7:0] psc_addr_t;
	typedef logic [31:0] psc_data_t;
	typedef enum logic [1:0]
	{
		PSC_D0 = 2'b00,
		PSC_D1 = 2'b01,
		PSC_D2 = 2'b10
	} psc_pstate_t;
endpackage : psc_pkg
`default_nettype wire

// File: psc_tb_top.sv
/*
 Testbench of the power-state controller: host end and device end joined
 by the bus interface, driven through the host's user port.
 Assumes the shortened resume and pulse counts set below.
*/
`timescale 1ns/10ps
`default_nettype none
`include "psc_cfg.svh"
module psc_tb_top;
	import psc_pkg::*;
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	psc_addr_t usr_addr_i = '0;
	psc_data_t usr_wdata_i = '0;
	logic usr_wr_i = 1'b0;
	logic usr_rd_i = 1'b0;
	logic wake_frame_det_i = 1'b0;
	logic carrier_i = 1'b0;
	psc_data_t usr_rdata_o;
	logic usr_rvalid_o, usr_refused_o, dev_ready_o, phy_energy_powerdown_o;
	logic wake_pin_o, irq_o, mac_clk_en_o, host_clk_en_o, rxpm_clk_en_o, int_clk_en_o;
	logic phy_low_power_o;
	psc_pstate_t state_o;
	int n_fail = 0;
	int check_count = 0;
	psc_data_t q;
	always #12.5 ref_clk_i = ~ref_clk_i;
	// ----------------------------------------------------------------
	// the two ends and the checker
	// ----------------------------------------------------------------
	psc_bus_if bus ();
	psc_dev #(.RESUME_CYC(8), .PULSE_CYC(16)) psc_dev_i (.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i), .bus(bus), .wake_frame_det_i(wake_frame_det_i),
		.carrier_i(carrier_i), .wake_pin_o(wake_pin_o), .irq_o(irq_o),
		.mac_clk_en_o(mac_clk_en_o), .host_clk_en_o(host_clk_en_o),
		.rxpm_clk_en_o(rxpm_clk_en_o), .int_clk_en_o(int_clk_en_o),
		.phy_low_power_o(phy_low_power_o), .state_o(state_o));
	psc_host psc_host_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .bus(bus),
		.usr_addr_i(usr_addr_i), .usr_wdata_i(usr_wdata_i), .usr_wr_i(usr_wr_i),
		.usr_rd_i(usr_rd_i), .usr_rdata_o(usr_rdata_o), .usr_rvalid_o(usr_rvalid_o),
		.usr_refused_o(usr_refused_o), .dev_ready_o(dev_ready_o),
		.phy_energy_powerdown_o(phy_energy_powerdown_o));
	psc_link_asserts psc_link_asserts_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata),
		.state_o(state_o), .mac_clk_en_o(mac_clk_en_o), .host_clk_en_o(host_clk_en_o),
		.rxpm_clk_en_o(rxpm_clk_en_o), .int_clk_en_o(int_clk_en_o),
		.phy_low_power_o(phy_low_power_o));
	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic check(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1)
		begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : check
	task automatic acc(input logic w, input psc_addr_t a, input psc_data_t d, input logic rf);
		int k;
		q = '0;
		@(posedge ref_clk_i);
		usr_addr_i <= a;
		usr_wdata_i <= d;
		usr_wr_i <= w;
		usr_rd_i <= !w;
		@(posedge ref_clk_i);
		usr_wr_i <= 1'b0;
		usr_rd_i <= 1'b0;
		#1;
		check(usr_refused_o === rf, "refusal flag unexpected");
		if (!w && !rf)
		begin
			for (k = 0; k < 8 && usr_rvalid_o !== 1'b1; k++)
			begin
				@(posedge ref_clk_i);
				#1;
			end
			check(usr_rvalid_o === 1'b1, "read data never came");
			q = usr_rdata_o;
		end
	endtask : acc
	task automatic rd(input psc_addr_t a, input psc_data_t e, input logic rf);
		acc(1'b0, a, '0, rf);
		if (!rf)
			check(q === e, $sformatf("read %h gave %h, expected %h", a, q, e));
	endtask : rd
	task automatic poll_ready();
		int k;
		for (k = 0; k < 12; k++)
		begin
			acc(1'b0, `PSC_OFS_PMC, '0, 1'b0);
			if (q[`PSC_PMC_READY] === 1'b1)
				break;
		end
		check(dev_ready_o === 1'b1, "ready not seen after wake");
	endtask : poll_ready
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		#100000;
		n_fail++;
		tally_and_finish();
	end
	initial
	begin
		repeat (8) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		rd(`PSC_OFS_PMC, 32'h0000_0100, 1'b0);
		rd(`PSC_OFS_WAKE_TEST, `PSC_WAKE_TEST_VAL, 1'b0);
		rd(8'h10, 32'h0000_0000, 1'b0);
		// sleep one, woken by a wake frame
		acc(1'b1, `PSC_OFS_INT_EN, 32'h0000_0001, 1'b0);
		acc(1'b1, `PSC_OFS_PMC, 32'h0000_0070, 1'b0);
		rd(`PSC_OFS_PMC, 32'h0000_0170, 1'b0);
		acc(1'b1, `PSC_OFS_PMC, 32'h0000_0071, 1'b0);
		repeat (4) @(posedge ref_clk_i);
		#1;
		check(state_o === PSC_D1 && mac_clk_en_o === 1'b0 && rxpm_clk_en_o === 1'b1, "no D1");
		rd(`PSC_OFS_PMC, 32'h0000_0071, 1'b0);
		rd(`PSC_OFS_WAKE_TEST, '0, 1'b1);
		@(posedge ref_clk_i);
		wake_frame_det_i <= 1'b1;
		@(posedge ref_clk_i);
		wake_frame_det_i <= 1'b0;
		repeat (5) @(posedge ref_clk_i);
		#1;
		check(wake_pin_o === 1'b1 && irq_o === 1'b1, "frame wake not signalled");
		rd(`PSC_OFS_PMC, 32'h0000_0079, 1'b0);
		acc(1'b1, `PSC_OFS_WAKE_TEST, 32'h0000_0000, 1'b0);
		acc(1'b1, `PSC_OFS_INTERRUPT_STATUS_REGISTER, 32'h0000_0001, 1'b1);
		poll_ready();
		check(state_o === PSC_D0 && mac_clk_en_o === 1'b1, "not back in D0");
		rd(`PSC_OFS_PMC, 32'h0000_0178, 1'b0);
		acc(1'b1, `PSC_OFS_INTERRUPT_STATUS_REGISTER, 32'h0000_0001, 1'b0);
		rd(`PSC_OFS_INTERRUPT_STATUS_REGISTER, 32'h0000_0001, 1'b0);
		acc(1'b1, `PSC_OFS_PMC, 32'h0000_007C, 1'b0);
		acc(1'b1, `PSC_OFS_INTERRUPT_STATUS_REGISTER, 32'h0000_0001, 1'b0);
		rd(`PSC_OFS_INTERRUPT_STATUS_REGISTER, 32'h0000_0000, 1'b0);
		// sleep two with carrier already up, pulsed pin
		@(posedge ref_clk_i);
		carrier_i <= 1'b1;
		acc(1'b1, `PSC_OFS_PMC, 32'h0000_00F0, 1'b0);
		rd(`PSC_OFS_PMC, 32'h0000_01F0, 1'b0);
		acc(1'b1, `PSC_OFS_PMC, 32'h0000_00F2, 1'b0);
		check(phy_energy_powerdown_o === 1'b1, "powerdown not set first");
		repeat (10) @(posedge ref_clk_i);
		#1;
		check(state_o === PSC_D2 && int_clk_en_o === 1'b0 && phy_low_power_o === 1'b1,
			"no D2");
		check(wake_pin_o === 1'b1, "carrier wake pin low");
		repeat (25) @(posedge ref_clk_i);
		#1;
		check(wake_pin_o === 1'b0, "pulsed pin still high");
		rd(`PSC_OFS_PMC, 32'h0000_00F6, 1'b0);
		acc(1'b1, `PSC_OFS_WAKE_TEST, 32'h0000_1234, 1'b0);
		poll_ready();
		check(phy_energy_powerdown_o === 1'b0, "powerdown not cleared");
		rd(`PSC_OFS_PMC, 32'h0000_01F4, 1'b0);
		@(posedge ref_clk_i);
		carrier_i <= 1'b0;
		acc(1'b1, `PSC_OFS_PMC, 32'h0000_00F4, 1'b0);
		rd(`PSC_OFS_PMC, 32'h0000_01F0, 1'b0);
		tally_and_finish();
	end
endmodule : psc_tb_top
`default_nettype wire
